//--- hw/sound_dac_irq_rate_tone_regs.sv
// Purpose: AXI4-Lite register bank with interrupt flags, resampler tick and tone generator
// Assumes: clk is the DAC operating clock; events arrive as one-cycle pulses on clk
// Notes: Processor writes arrive on their own port, take effect only while sound_processor_enable is set, and then win over bus writes
//
// Our own choices: register access over AXI4-Lite and the placing of the registers.
`timescale 1ns/100ps
module sound_dac_irq_rate_tone_regs
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // AXI4-Lite write address
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [7:0] s_axi_awaddr,
  // AXI4-Lite write data
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  // AXI4-Lite write response
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  output logic [1:0] s_axi_bresp,
  // AXI4-Lite read address
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  input wire logic [7:0] s_axi_araddr,
  // AXI4-Lite read data
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  // Cause events, one-cycle pulses
  input wire logic [3:0] irq_events,
  // Sound processor access to flags and enables
  input wire logic [3:0] proc_flag_clear,
  input wire logic proc_enable_write,
  input wire logic [3:0] proc_enable_data,
  // Outputs
  output logic irq,
  output logic dac_clock_enable,
  output logic sample_tick,
  output logic tone_out,
  output logic sound_processor_enable
);

  sound_dac_pkg::state_s cur;
  sound_dac_pkg::state_s next_cur;

  logic wr_fire;
  logic rd_fire;
  logic bus_wr_ok;
  logic [31:0] wmask;
  logic [31:0] wval;
  logic [17:0] tone_limit;
  logic [11:0] phase_sum;

  //////////////////////////////////////////////////////////////////////////////
  // Bus handshake
  assign s_axi_awready = !cur.aw_got && !cur.bvalid;
  assign s_axi_wready = !cur.w_got && !cur.bvalid;
  assign s_axi_arready = !cur.rvalid;
  assign s_axi_bvalid = cur.bvalid;
  assign s_axi_bresp = cur.bresp;
  assign s_axi_rvalid = cur.rvalid;
  assign s_axi_rdata = cur.rdata;
  assign s_axi_rresp = cur.rresp;

  assign irq = |(cur.flags & cur.enables);
  assign dac_clock_enable = cur.dac_on;
  assign sample_tick = cur.sample_tick;
  assign tone_out = cur.tone_out;
  assign sound_processor_enable = cur.proc_en;

  // Last count of a tone half period, 4*div+3; a divider of 0xFFFF would overflow 4*div+4 in 18 bits
  assign tone_limit = {cur.tone, 2'b11};

  assign phase_sum = cur.phase + sound_dac_pkg::phase_full;

  always_comb
  begin
    next_cur = cur;
    next_cur.sample_tick = 1'b0;
    wr_fire = 1'b0;
    rd_fire = 1'b0;
    bus_wr_ok = 1'b0;
    wmask = {{8{s_axi_wstrb[3]}}, {8{s_axi_wstrb[2]}}, {8{s_axi_wstrb[1]}}, {8{s_axi_wstrb[0]}}};
    wval = 32'h0000_0000;

    if (s_axi_awvalid && s_axi_awready)
    begin
      next_cur.aw_got = 1'b1;
      next_cur.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready)
    begin
      next_cur.w_got = 1'b1;
      next_cur.w_data = s_axi_wdata;
      next_cur.w_strb = s_axi_wstrb;
    end
    if (s_axi_bvalid && s_axi_bready)
      next_cur.bvalid = 1'b0;

    //////////////////////////////////////////////////////////////////////////
    // Register writes
    wr_fire = cur.aw_got && cur.w_got;
    wmask = {{8{cur.w_strb[3]}}, {8{cur.w_strb[2]}}, {8{cur.w_strb[1]}}, {8{cur.w_strb[0]}}};
    wval = cur.w_data & wmask;
    if (wr_fire)
    begin
      next_cur.aw_got = 1'b0;
      next_cur.w_got = 1'b0;
      next_cur.bvalid = 1'b1;
      next_cur.bresp = sound_dac_pkg::resp_okay;
      bus_wr_ok = 1'b1;
      case (cur.aw_addr)
        sound_dac_pkg::off_irq_flags:
          next_cur.flags = cur.flags & ~wval[3:0];
        sound_dac_pkg::off_irq_enables:
          next_cur.enables = (cur.enables & ~wmask[3:0]) | wval[3:0];
        sound_dac_pkg::off_resampler_rate:
          next_cur.rate = (cur.rate & ~wmask[10:0]) | wval[10:0];
        sound_dac_pkg::off_tone_divider:
          next_cur.tone = (cur.tone & ~wmask[15:0]) | wval[15:0];
        sound_dac_pkg::off_control:
        begin
          if (cur.w_strb[0])
          begin
            next_cur.dac_on = cur.w_data[sound_dac_pkg::bit_dac_clock_enable];
            next_cur.tone_on = cur.w_data[sound_dac_pkg::bit_tone_generator_on];
            next_cur.proc_en = cur.w_data[sound_dac_pkg::bit_sound_processor_enable];
          end
        end
        default:
        begin
          next_cur.bresp = sound_dac_pkg::resp_slverr;
          bus_wr_ok = 1'b0;
        end
      endcase
    end

    // Processor owns flags and enables while enabled; its writes take priority
    if (cur.proc_en)
    begin
      next_cur.flags = next_cur.flags & ~proc_flag_clear;
      if (proc_enable_write)
        next_cur.enables = proc_enable_data;
    end

    // Set wins over any clear in the same cycle
    next_cur.flags = next_cur.flags | irq_events;

    //////////////////////////////////////////////////////////////////////////
    // Register reads
    rd_fire = s_axi_arvalid && s_axi_arready;
    if (s_axi_rvalid && s_axi_rready)
      next_cur.rvalid = 1'b0;
    if (rd_fire)
    begin
      next_cur.rvalid = 1'b1;
      next_cur.rresp = sound_dac_pkg::resp_okay;
      case (s_axi_araddr)
        sound_dac_pkg::off_irq_flags:
          next_cur.rdata = {28'h000_0000, cur.flags};
        sound_dac_pkg::off_irq_enables:
          next_cur.rdata = {28'h000_0000, cur.enables};
        sound_dac_pkg::off_resampler_rate:
          next_cur.rdata = {21'h00_0000, cur.rate};
        sound_dac_pkg::off_tone_divider:
          next_cur.rdata = {16'h0000, cur.tone};
        sound_dac_pkg::off_control:
          next_cur.rdata = {29'h0000_0000, cur.proc_en, cur.tone_on, cur.dac_on};
        default:
        begin
          next_cur.rdata = 32'h0000_0000;
          next_cur.rresp = sound_dac_pkg::resp_slverr;
        end
      endcase
    end

    //////////////////////////////////////////////////////////////////////////
    // Resampler: phase accumulator adds 1024 each clock, ticks at each wrap of rate
    // A rate of zero would divide by zero, so it holds the tick off
    if (cur.dac_on && cur.rate != 11'h000)
    begin
      if (phase_sum >= {1'b0, cur.rate})
      begin
        next_cur.phase = phase_sum - {1'b0, cur.rate};
        next_cur.sample_tick = 1'b1;
      end
      else
        next_cur.phase = phase_sum;
    end
    else
      next_cur.phase = 12'h000;

    //////////////////////////////////////////////////////////////////////////
    // Tone generator, toggles each half period; period is (4*div+4)*2 clocks
    if (cur.dac_on && cur.tone_on)
    begin
      if (cur.tone_cnt >= tone_limit)
      begin
        next_cur.tone_cnt = 18'h0_0000;
        next_cur.tone_out = !cur.tone_out;
      end
      else
        next_cur.tone_cnt = cur.tone_cnt + 18'h0_0001;
    end
    else
    begin
      next_cur.tone_cnt = 18'h0_0000;
      next_cur.tone_out = 1'b0;
    end
    next_cur.tone_sub = 3'h0;
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      cur <= '0;
      cur.flags <= sound_dac_pkg::irq_reset;
      cur.enables <= sound_dac_pkg::irq_reset;
      cur.rate <= sound_dac_pkg::rate_reset;
      cur.tone <= sound_dac_pkg::tone_reset;
    end
    else
      cur <= next_cur;
  end

endmodule : sound_dac_irq_rate_tone_regs

//--- hw/sound_dac_pkg.sv
// Purpose: Shared constants and types for the sound DAC register bank
// Assumes: AXI4-Lite, 32-bit data, one word per register
// Notes: Offsets are local choices
package sound_dac_pkg;
  localparam logic [7:0] off_irq_flags = 8'h00;
  localparam logic [7:0] off_irq_enables = 8'h04;
  localparam logic [7:0] off_resampler_rate = 8'h08;
  localparam logic [7:0] off_tone_divider = 8'h0C;
  localparam logic [7:0] off_control = 8'h10;
  localparam int irq_w = 4;
  localparam int rate_w = 11;
  localparam int tone_w = 16;
  localparam int bit_ch0_data_request = 0;
  localparam int bit_ch0_error = 1;
  localparam int bit_ch1_data_request = 2;
  localparam int bit_ch1_error = 3;
  localparam int bit_dac_clock_enable = 0;
  localparam int bit_tone_generator_on = 1;
  localparam int bit_sound_processor_enable = 2;
  localparam logic [3:0] irq_reset = 4'h0;
  localparam logic [10:0] rate_reset = 11'h400;
  localparam logic [15:0] tone_reset = 16'h4000;
  localparam logic [1:0] resp_okay = 2'b00;
  localparam logic [1:0] resp_slverr = 2'b10;
  localparam int phase_w = 12;
  localparam logic [11:0] phase_full = 12'h400;

  typedef struct packed {
    logic [3:0] flags;
    logic [3:0] enables;
    logic [10:0] rate;
    logic [15:0] tone;
    logic dac_on;
    logic tone_on;
    logic proc_en;
    logic aw_got;
    logic [7:0] aw_addr;
    logic w_got;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic [11:0] phase;
    logic sample_tick;
    logic [17:0] tone_cnt;
    logic [2:0] tone_sub;
    logic tone_out;
  } state_s;
endpackage : sound_dac_pkg

//--- verif/sound_dac_monitor.sv
// Purpose: Port checks for the sound DAC register bank
// Assumes: One clock, rst async active high
// Notes: Bound below to every instance
`timescale 1ns/100ps
module sound_dac_monitor
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Bus handshakes
  input wire logic s_axi_awready,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  // Side ports
  input wire logic [3:0] irq_events,
  input wire logic [3:0] proc_flag_clear,
  input wire logic proc_enable_write,
  input wire logic irq,
  input wire logic dac_clock_enable,
  input wire logic sample_tick,
  input wire logic tone_out
);
  default clocking @(posedge clk);
  endclocking
  default disable iff (rst);
  ////////////////////////////////////////
  // Event set, bus write landing or processor enable write are the only ways up
  irq_rise_a: assert property ($rose(irq) |-> $past(|irq_events) || s_axi_bvalid || $past(proc_enable_write))
    else $error("irq rose without cause");
  irq_fall_a: assert property ($fell(irq) |-> s_axi_bvalid || $past(|proc_flag_clear) || $past(proc_enable_write))
    else $error("irq fell without clear");
  tone_stop_a: assert property (!dac_clock_enable && !$past(dac_clock_enable) |-> !tone_out)
    else $error("tone with clock stopped");
  tick_stop_a: assert property (!dac_clock_enable && !$past(dac_clock_enable) |-> !sample_tick)
    else $error("tick with clock stopped");
  b_block_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken during response");
  wr_answer_a: assert property ($rose(s_axi_bvalid) |-> $past(!s_axi_awready && !s_axi_wready))
    else $error("response without held write");
  rd_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  rd_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken during answer");
  cover property ($rose(irq));
  cover property ($rose(tone_out));
  cover property (sample_tick);
endmodule : sound_dac_monitor
bind sound_dac_irq_rate_tone_regs sound_dac_monitor u_mon
(
  .clk(clk), .rst(rst), .s_axi_awready(s_axi_awready), .s_axi_wready(s_axi_wready),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rvalid(s_axi_rvalid), .irq_events(irq_events), .proc_flag_clear(proc_flag_clear),
  .proc_enable_write(proc_enable_write), .irq(irq), .dac_clock_enable(dac_clock_enable),
  .sample_tick(sample_tick), .tone_out(tone_out)
);

//--- verif/testbench.sv
// Purpose: Self-checking bench for the sound DAC register bank
// Assumes: bready and rready held high, full strobes
// Notes: Counts are taken over whole tone and tick periods
`timescale 1ns/100ps
module testbench;
  logic clk, rst, awvalid, wvalid, arvalid, pwr, awready, wready, bvalid, arready, rvalid, irq, dac, tick, tone, pen;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0] ev, pclr, pdat;
  logic [1:0] bresp, rresp;
  int bad_count, check_count, t, g;
  sound_dac_irq_rate_tone_regs u_dut
  (
    .clk(clk), .rst(rst), .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_awaddr(awaddr),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
    .s_axi_bvalid(bvalid), .s_axi_bready(1'b1), .s_axi_bresp(bresp), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_araddr(araddr), .s_axi_rvalid(rvalid), .s_axi_rready(1'b1),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .irq_events(ev), .proc_flag_clear(pclr),
    .proc_enable_write(pwr), .proc_enable_data(pdat), .irq(irq), .dac_clock_enable(dac),
    .sample_tick(tick), .tone_out(tone), .sound_processor_enable(pen)
  );
  ////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp)
    begin
      bad_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    int n;
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    n = 0;
    do
    begin
      @(posedge clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      n++;
    end
    while (!bvalid && n < 40);
    chk(32'(bresp), 32'h0000_0000);
  endtask : wr
  // Addresses past the control word are unmapped and must answer with an error
  task automatic rc(input logic [7:0] a, input logic [31:0] e);
    int n;
    araddr <= a;
    arvalid <= 1'b1;
    n = 0;
    do
    begin
      @(posedge clk);
      if (arready) arvalid <= 1'b0;
      n++;
    end
    while (!rvalid && n < 40);
    chk(rdata, e);
    chk(32'(rresp), a > 8'h10 ? 32'h0000_0002 : 32'h0000_0000);
  endtask : rc
  task automatic watch(input int n);
    logic p;
    t = 0;
    g = 0;
    @(negedge clk);
    p = tone;
    repeat (n)
    begin
      @(negedge clk);
      t += int'(tick);
      g += int'(tone != p);
      p = tone;
    end
    @(posedge clk);
  endtask : watch
  task automatic conclude();
    $display("checks=%0d bad=%0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : conclude
  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  initial
  begin
    repeat (20000) @(posedge clk);
    bad_count++;
    conclude();
  end
  initial
  begin
    rst = 1'b1;
    {awvalid, wvalid, arvalid, pwr, ev, pclr, pdat, awaddr, araddr, wdata} = 64'h0;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    rc(sound_dac_pkg::off_irq_flags, 32'h0000_0000);
    rc(sound_dac_pkg::off_irq_enables, 32'h0000_0000);
    rc(sound_dac_pkg::off_resampler_rate, 32'h0000_0400);
    rc(sound_dac_pkg::off_tone_divider, 32'h0000_4000);
    rc(8'h14, 32'h0000_0000);
    $display("reset values done");
    for (int i = 0; i < 4; i++)
    begin
      ev <= 4'(1 << i);
      @(posedge clk);
      ev <= 4'h0;
      rc(sound_dac_pkg::off_irq_flags, 32'(1 << i));
      chk(32'(irq), 32'h0000_0000);
      wr(sound_dac_pkg::off_irq_enables, 32'(1 << i));
      rc(sound_dac_pkg::off_irq_enables, 32'(1 << i));
      chk(32'(irq), 32'h0000_0001);
      wr(sound_dac_pkg::off_irq_flags, 32'h0000_000f ^ 32'(1 << i));
      chk(32'(irq), 32'h0000_0001);
      wr(sound_dac_pkg::off_irq_flags, 32'(1 << i));
      chk(32'(irq), 32'h0000_0000);
    end
    $display("interrupt flags done");
    wr(sound_dac_pkg::off_resampler_rate, 32'hffff_ffff);
    rc(sound_dac_pkg::off_resampler_rate, 32'h0000_07ff);
    wr(sound_dac_pkg::off_tone_divider, 32'hffff_0001);
    rc(sound_dac_pkg::off_tone_divider, 32'h0000_0001);
    wr(sound_dac_pkg::off_resampler_rate, 32'h0000_0600);
    wr(sound_dac_pkg::off_control, 32'h0000_0003);
    watch(24);
    watch(240);
    chk(32'(t), 32'h0000_00a0);
    chk(32'(g), 32'h0000_001e);
    wr(sound_dac_pkg::off_control, 32'h0000_0001);
    watch(8);
    watch(48);
    chk(32'(t), 32'h0000_0020);
    chk(32'(g) + 32'(tone), 32'h0000_0000);
    wr(sound_dac_pkg::off_control, 32'h0000_0002);
    watch(8);
    watch(48);
    chk(32'(t + g) + 32'(tone), 32'h0000_0000);
    $display("rate and tone done");
    // No bus writes to flags, enables or rate from here on: the processor owns flags and enables
    wr(sound_dac_pkg::off_control, 32'h0000_0004);
    chk(32'(pen), 32'h0000_0001);
    ev <= 4'h2;
    pwr <= 1'b1;
    pdat <= 4'h2;
    @(posedge clk);
    ev <= 4'h0;
    pwr <= 1'b0;
    @(negedge clk);
    chk(32'(irq), 32'h0000_0001);
    @(posedge clk);
    pclr <= 4'h2;
    @(posedge clk);
    pclr <= 4'h0;
    rc(sound_dac_pkg::off_irq_flags, 32'h0000_0000);
    chk(32'(irq), 32'h0000_0000);
    $display("processor access done");
    conclude();
  end
endmodule : testbench
